// file: srn_pkg.sv
// Package for the system reset and non-maskable interrupt controller
package srn_pkg;

  // Vector word addresses
  localparam logic [15:0] SRN_VEC_RESET = 16'hfffe;
  localparam logic [15:0] SRN_VEC_NMI   = 16'hfffc;
  localparam logic [15:0] SRN_VEC_STEP  = 16'h0002;
  localparam int          SRN_VEC_COUNT = 16;

  // Reset values of the control state
  localparam logic        SRN_RST_PIN_MODE  = 1'b0;  // 0 is reset mode
  localparam logic        SRN_RST_WDT_MODE  = 1'b0;  // 0 is watchdog mode
  localparam logic [15:0] SRN_RST_PSW       = 16'h0000;
  localparam logic [2:0]  SRN_RST_NMI_EN    = 3'h0;

  // Field positions in the enable and flag triples
  localparam int SRN_F_PIN   = 0;
  localparam int SRN_F_OSC   = 1;
  localparam int SRN_F_FLASH = 2;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    SRN_ST_HOLD  = 3'b001,
    SRN_ST_FETCH = 3'b010,
    SRN_ST_RUN   = 3'b100
  } srn_state_t;

  // Reset causes as seen by the core side
  typedef struct packed {
    logic supply_drop_reset;
    logic system_clear;
  } srn_resets_t;

  // Non-maskable enables, written by software
  typedef struct packed {
    logic flash_violation_irq_en;
    logic osc_fault_irq_en;
    logic pin_event_irq_en;
  } srn_nmi_en_t;

endpackage : srn_pkg

// file: srn_sync.sv
// Two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps

module srn_sync
  import srn_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta_r;

  // Two stages of capture
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      meta_r <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule : srn_sync

// file: srn_ctrl.sv
// System reset sequencer and non-maskable interrupt controller
`timescale 1ns/1ps

module srn_ctrl
  import srn_pkg::*;
#(
  parameter int NUM_IRQ = 13   // Maskable sources below the top two
)
(
  // Clock and power-up reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_reset,
  // Asynchronous reset causes
  input  wire logic               i_reset_pin_n,
  input  wire logic               i_supply_monitor_low,
  input  wire logic               i_monitor_reset_option,
  // Watchdog, oscillator and flash events, same clock
  input  wire logic               i_wdt_expire,
  input  wire logic               i_wdt_key_viol,
  input  wire logic               i_flash_key_viol,
  input  wire logic               i_osc_fault,
  input  wire logic               i_flash_access_viol,
  // Software control
  input  wire logic               i_pin_nmi_mode_wr,
  input  wire logic               i_pin_nmi_mode,
  input  wire logic               i_pin_edge_select,
  input  wire logic               i_wdt_interval_wr,
  input  wire logic               i_wdt_interval,
  input  wire logic               i_nmi_en_wr,
  input  wire srn_nmi_en_t        i_nmi_en,
  input  wire logic               i_flag_clr,
  input  wire logic               i_psw_wr,
  input  wire logic [15:0]        i_psw,
  // Maskable requests and core acceptance
  input  wire logic [NUM_IRQ-1:0] i_irq_req,
  input  wire logic               i_irq_ack,
  // Reset outputs and pin control
  output srn_resets_t             o_resets,
  output logic                    o_pin_nmi_mode,
  output logic                    o_gpio_force_input,
  output logic                    o_wdt_interval,
  output logic [15:0]             o_psw,
  output logic                    o_global_irq_enable,
  // Core start and interrupt vectoring
  output logic                    o_fetch_vector,
  output logic [15:0]             o_vector_addr,
  output logic                    o_irq_pending,
  output srn_nmi_en_t             o_nmi_en,
  // Cause flags: watchdog, key, pin, osc, flash
  output logic [4:0]              o_cause_flags
);

  // Elaboration check; assertion clock and reset set once here
  if (NUM_IRQ < 1 || NUM_IRQ > SRN_VEC_COUNT - 2)
    $error("NUM_IRQ out of range");
  default clocking a_clk @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);

  // Synchronised pin level, supply monitor low
  logic [1:0] sync_w;

  // All state in one struct
  typedef struct packed {
    srn_state_t  state;
    logic        por;
    logic        sys_clr;
    logic        pin_mode;
    logic        edge_sel;
    logic        pin_prev;
    logic        wdt_ival;
    logic [15:0] psw;
    srn_nmi_en_t en;
    logic [4:0]  flags;
    logic        fetch;
    logic [15:0] vec;
  } srn_st_t;

  srn_st_t st_r;
  srn_st_t st_nxt;

  logic pin_lvl;       // Synchronised pin level
  logic por_cause;     // Full reset cause this cycle
  logic clr_cause;     // Clear cause this cycle
  logic edge_hit;      // Selected edge seen
  logic [2:0] nmi_req; // Enabled non-maskable requests

  // Pin and supply monitor synchronised before use
  srn_sync #(.WIDTH(2)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_async   ({i_reset_pin_n, i_supply_monitor_low}),
    .o_sync    (sync_w)
  );

  // Cause and request decode
  always_comb
  begin
    pin_lvl   = sync_w[1];
    // Full reset causes
    por_cause = (!st_r.pin_mode && !pin_lvl) ||
                (sync_w[0] && i_monitor_reset_option);
    // Clear causes; full reset is one of them
    clr_cause = por_cause || (i_wdt_expire && !st_r.wdt_ival) ||
                i_wdt_key_viol || i_flash_key_viol;
    // Edge compares against the level seen last cycle, so an
    // edge-select change in interrupt mode cannot fire by itself
    edge_hit  = st_r.pin_mode &&
                (st_r.edge_sel ? (st_r.pin_prev && !pin_lvl)
                               : (!st_r.pin_prev && pin_lvl));
    // Only three sources, gated by own enables
    nmi_req   = {st_r.flags[4] & st_r.en.flash_violation_irq_en,
                 st_r.flags[3] & st_r.en.osc_fault_irq_en,
                 st_r.flags[2] & st_r.en.pin_event_irq_en};
  end

  // Next-state logic
  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.por   = por_cause;
    st_nxt.sys_clr = clr_cause;
    st_nxt.fetch = 1'b0;
    // Select and reference level tracked each cycle
    st_nxt.edge_sel = i_pin_edge_select;
    st_nxt.pin_prev = pin_lvl;
    if (i_pin_nmi_mode_wr)
      st_nxt.pin_mode = i_pin_nmi_mode;
    if (i_wdt_interval_wr)
      st_nxt.wdt_ival = i_wdt_interval;
    if (i_psw_wr)
      st_nxt.psw = i_psw;
    if (i_nmi_en_wr)
      st_nxt.en = i_nmi_en;   // Software re-arms
    // Flags: clear first, hardware set wins
    if (i_flag_clr)
      st_nxt.flags = '0;
    if (i_wdt_expire && !st_r.wdt_ival)
      st_nxt.flags[0] = 1'b1;
    if (i_wdt_key_viol || i_flash_key_viol)
      st_nxt.flags[1] = 1'b1;
    if (edge_hit)
      st_nxt.flags[2] = 1'b1;   // Set regardless of enable
    if (i_osc_fault)
      st_nxt.flags[3] = 1'b1;
    if (i_flash_access_viol)
      st_nxt.flags[4] = 1'b1;
    unique case (st_r.state)
      SRN_ST_HOLD:
      begin
        if (!clr_cause)
          st_nxt.state = SRN_ST_FETCH;
      end
      SRN_ST_FETCH:
      begin
        st_nxt.fetch = 1'b1;
        st_nxt.vec   = SRN_VEC_RESET;
        st_nxt.state = SRN_ST_RUN;
      end
      SRN_ST_RUN:
      begin
        if (i_irq_ack)
        begin
          // Daisy chain: reset, then NMI, then lower vectors
          st_nxt.fetch = 1'b1;
          if (|nmi_req)
          begin
            st_nxt.vec = SRN_VEC_NMI;
            st_nxt.en  = SRN_RST_NMI_EN;
          end
          else
          begin
            for (int i = NUM_IRQ - 1; i >= 0; i--)
            begin
              if (i_irq_req[i])
              begin
                // Lower index means lower address
                st_nxt.vec = SRN_VEC_NMI -
                  16'(NUM_IRQ - i) * SRN_VEC_STEP;
                break;
              end
            end
          end
          st_nxt.psw = SRN_RST_PSW;
        end
      end
      default:
        st_nxt.state = SRN_ST_HOLD;
    endcase
    // Any clear: pin back to reset mode, core held
    if (clr_cause)
    begin
      st_nxt.state    = SRN_ST_HOLD;
      st_nxt.pin_mode = SRN_RST_PIN_MODE;
      st_nxt.en       = SRN_RST_NMI_EN;
      st_nxt.fetch    = 1'b0;
    end
    // Full reset initial conditions
    if (por_cause)
    begin
      st_nxt.psw      = SRN_RST_PSW;
      st_nxt.wdt_ival = SRN_RST_WDT_MODE;
    end
  end

  // State register, power-up reset acts as a full reset
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      st_r          <= '0;
      st_r.state    <= SRN_ST_HOLD;
      st_r.por      <= 1'b1;
      st_r.sys_clr  <= 1'b1;
      st_r.pin_mode <= SRN_RST_PIN_MODE;
      st_r.wdt_ival <= SRN_RST_WDT_MODE;
      st_r.psw      <= SRN_RST_PSW;
      st_r.en       <= SRN_RST_NMI_EN;
      st_r.vec      <= SRN_VEC_RESET;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs from flip-flops, except o_irq_pending, which also decodes i_irq_req
  always_comb
  begin
    o_resets.supply_drop_reset = st_r.por;
    o_resets.system_clear      = st_r.sys_clr;
    o_gpio_force_input         = st_r.por;
    o_pin_nmi_mode             = st_r.pin_mode;
    o_wdt_interval             = st_r.wdt_ival;
    o_psw                      = st_r.psw;
    o_global_irq_enable        = st_r.psw[3];
    o_fetch_vector             = st_r.fetch;
    o_vector_addr              = st_r.vec;
    o_nmi_en                   = st_r.en;
    o_cause_flags              = st_r.flags;
    o_irq_pending              = (st_r.state == SRN_ST_RUN) &&
                                 ((|nmi_req) ||
                                  ((|i_irq_req) && st_r.psw[3]));
  end

  // Full reset always comes with a clear
  a_por_has_clr: assert property (o_resets.supply_drop_reset |->
    o_resets.system_clear) else $error("full reset without clear");
  // Pin low in reset mode gives full reset next cycle
  a_pin_low_por: assert property ((!st_r.pin_mode && !pin_lvl) |=>
    o_resets.supply_drop_reset) else $error("pin low missed");
  // Watchdog expiry in watchdog mode gives clear
  a_wdt_clear: assert property ((i_wdt_expire && !o_wdt_interval)
    |=> o_resets.system_clear) else $error("watchdog clear missed");
  // Clear returns pin to reset mode
  a_clear_pin_mode: assert property (o_resets.system_clear |->
    !o_pin_nmi_mode) else $error("pin not in reset mode");
  // Full reset leaves status word clear, watchdog mode
  a_por_init: assert property (o_resets.supply_drop_reset |->
    (o_psw == SRN_RST_PSW && !o_wdt_interval)) else $error("bad init");
  // Reset release fetches the reset vector one cycle after the clear falls
  sequence s_release;
    $fell(o_resets.system_clear) ##1 o_fetch_vector;
  endsequence
  a_reset_vector: assert property (s_release |->
    o_vector_addr == SRN_VEC_RESET) else $error("reset vector wrong");
  // Accepted request with a live source takes 0FFFCh, drops enables
  a_nmi_take: assert property (
    st_r.state == SRN_ST_RUN && i_irq_ack && |nmi_req && !clr_cause
    |=> o_vector_addr == SRN_VEC_NMI && o_nmi_en == SRN_RST_NMI_EN)
    else $error("nmi acceptance wrong");
  // Pin event flag never rises straight after reset mode
  a_no_edge_reset: assert property (!st_r.pin_mode |=>
    !$rose(o_cause_flags[2])) else $error("pin event in reset mode");

endmodule : srn_ctrl

// file: srn_core_model.sv
// Behavioural processor core that answers reset and interrupt requests
`timescale 1ns/1ps

module srn_core_model
  import srn_pkg::*;
(
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  // Requests from the controller
  input  wire srn_resets_t i_resets,
  input  wire logic        i_irq_pending,
  input  wire logic        i_fetch_vector,
  input  wire logic [15:0] i_vector_addr,
  // Slow answer selects a five cycle acceptance delay
  input  wire logic        i_slow,
  // Acceptance and record of fetches
  output logic             o_irq_ack,
  output logic [7:0]       o_fetches,
  output logic [15:0]      o_last_vec
);
  logic [2:0] cnt_r;  // Cycles the request has waited
  logic       busy_r; // Accepted, vector not yet fetched

  // Accept a pending request after the chosen delay, record each fetch
  always_ff @(posedge i_sys_clk)
  begin
    o_irq_ack <= 1'b0;
    if (i_fetch_vector)
    begin
      o_fetches  <= o_fetches + 8'h01;
      o_last_vec <= i_vector_addr;
    end
    if (i_reset)
      o_fetches <= 8'h00;
    // Core stays held while any clear is active
    if (i_reset || i_resets.system_clear)
    begin
      cnt_r  <= 3'h0;
      busy_r <= 1'b0;
    end
    else if (busy_r)
      busy_r <= !i_fetch_vector;
    else if (!i_irq_pending)
      cnt_r <= 3'h0;
    else if (cnt_r >= (i_slow ? 3'h5 : 3'h0))
    begin
      o_irq_ack <= 1'b1;
      busy_r    <= 1'b1;
      cnt_r     <= 3'h0;
    end
    else
      cnt_r <= cnt_r + 3'h1;
  end
endmodule : srn_core_model

// file: srn_tb.sv
// Self-checking bench for the reset and non-maskable interrupt controller
`timescale 1ns/1ps

module tb
  import srn_pkg::*;
;
  // Design inputs
  logic i_sys_clk, i_reset, i_reset_pin_n, i_supply_monitor_low;
  logic i_monitor_reset_option, i_wdt_expire, i_wdt_key_viol;
  logic i_flash_key_viol, i_osc_fault, i_flash_access_viol;
  logic i_pin_nmi_mode_wr, i_pin_nmi_mode, i_pin_edge_select;
  logic i_wdt_interval_wr, i_wdt_interval, i_nmi_en_wr, i_flag_clr;
  logic i_psw_wr, slow;
  logic [15:0] i_psw;
  logic [12:0] i_irq_req;
  srn_nmi_en_t i_nmi_en;
  // Design and core outputs
  srn_resets_t o_resets;
  srn_nmi_en_t o_nmi_en;
  logic o_pin_nmi_mode, o_gpio_force_input, o_wdt_interval;
  logic o_global_irq_enable, o_fetch_vector, o_irq_pending, irq_ack;
  logic [15:0] o_psw, o_vector_addr, last_vec;
  logic [4:0]  o_cause_flags;
  logic [7:0]  fetches;
  int err_total, checks, cyc;

  srn_ctrl #(.NUM_IRQ(13)) i_srn_ctrl (.i_sys_clk, .i_reset,
    .i_reset_pin_n, .i_supply_monitor_low, .i_monitor_reset_option,
    .i_wdt_expire, .i_wdt_key_viol, .i_flash_key_viol, .i_osc_fault,
    .i_flash_access_viol, .i_pin_nmi_mode_wr, .i_pin_nmi_mode,
    .i_pin_edge_select, .i_wdt_interval_wr, .i_wdt_interval,
    .i_nmi_en_wr, .i_nmi_en, .i_flag_clr, .i_psw_wr, .i_psw,
    .i_irq_req, .i_irq_ack(irq_ack), .o_resets, .o_pin_nmi_mode,
    .o_gpio_force_input, .o_wdt_interval, .o_psw, .o_global_irq_enable,
    .o_fetch_vector, .o_vector_addr, .o_irq_pending, .o_nmi_en,
    .o_cause_flags);

  srn_core_model i_srn_core_model (.i_sys_clk, .i_reset,
    .i_resets(o_resets), .i_irq_pending(o_irq_pending),
    .i_fetch_vector(o_fetch_vector), .i_vector_addr(o_vector_addr),
    .i_slow(slow), .o_irq_ack(irq_ack), .o_fetches(fetches),
    .o_last_vec(last_vec));

  // Clock at 100 MHz
  initial
  begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // Step whole cycles, landing just after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : tick

  // Compare and count
  task automatic chk(input string nm, input logic [15:0] s, e);
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // One cycle strobe
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse

  // Wait a bounded time for the core to fetch, then judge the vector
  task automatic wait_fetch(input logic [15:0] e);
    int n;
    n = fetches;
    for (int i = 0; i < 60 && fetches == n; i++) tick(1);
    chk("fetched", fetches != n, 1'b1);
    chk("vector", last_vec, e);
  endtask : wait_fetch

  // Pin low in reset mode gives a full reset and fresh defaults
  task automatic t_pin_reset();
    i_psw = 16'h0008;
    pulse(i_psw_wr);
    pulse(i_wdt_interval_wr); // Software sets watchdog up
    i_reset_pin_n = 1'b0;
    tick(4);
    chk("resets", o_resets, 2'b11);
    chk("gpio", o_gpio_force_input, 1'b1);
    chk("psw", o_psw, SRN_RST_PSW);
    chk("wdt", o_wdt_interval, SRN_RST_WDT_MODE);
    i_reset_pin_n = 1'b1;
    wait_fetch(SRN_VEC_RESET);
  endtask : t_pin_reset

  // Watchdog expiry, key violations and the supply monitor option
  task automatic t_clears();
    pulse(i_wdt_interval_wr);
    pulse(i_wdt_expire);
    chk("interval", o_resets, 2'b00);
    i_wdt_interval = 1'b0;
    pulse(i_wdt_interval_wr);
    pulse(i_wdt_expire);
    chk("expire", o_resets, 2'b01);
    wait_fetch(SRN_VEC_RESET);
    chk("wdt flag", o_cause_flags[0], 1'b1);
    pulse(i_flag_clr);
    pulse(i_wdt_key_viol);
    chk("key", o_resets, 2'b01);
    wait_fetch(SRN_VEC_RESET);
    pulse(i_flash_key_viol);
    chk("fkey", o_resets, 2'b01);
    wait_fetch(SRN_VEC_RESET);
    chk("key flag", o_cause_flags[1], 1'b1);
    i_supply_monitor_low = 1'b1;
    tick(4);
    chk("mon off", o_resets, 2'b00);
    i_monitor_reset_option = 1'b1;
    tick(3);
    chk("mon on", o_resets, 2'b11);
    i_supply_monitor_low = 1'b0;
    wait_fetch(SRN_VEC_RESET);
  endtask : t_clears

  // Each source vectors to the shared slot and drops all enables
  task automatic t_nmi();
    // Select flipped in reset mode must leave no pin event
    i_pin_edge_select = 1'b1;
    tick(2);
    i_pin_edge_select = 1'b0;
    tick(4);
    chk("no edge", o_cause_flags[2], 1'b0);
    pulse(i_osc_fault);
    tick(2);
    chk("no en", o_irq_pending, 1'b0);
    for (int s = 0; s < 3; s++)
    begin
      slow = s[0];
      pulse(i_flag_clr);
      i_pin_nmi_mode = 1'b1;
      i_pin_edge_select = 1'b1;
      pulse(i_pin_nmi_mode_wr);
      i_nmi_en = srn_nmi_en_t'(3'h1 << s);
      pulse(i_nmi_en_wr); // Re-enable after servicing
      if (s == 0) i_reset_pin_n = 1'b0;
      if (s == 1) pulse(i_osc_fault);
      if (s == 2) pulse(i_flash_access_viol);
      wait_fetch(SRN_VEC_NMI);
      chk("en clr", o_nmi_en, 3'h0);
      chk("flag", o_cause_flags[2+s], 1'b1);
      i_reset_pin_n = 1'b1;
    end
    // Rising edge selected: fall ignored, rise flags with enables off
    i_pin_edge_select = 1'b0;
    pulse(i_flag_clr);
    i_reset_pin_n = 1'b0;
    tick(4);
    chk("no fall", o_cause_flags[2], 1'b0);
    i_reset_pin_n = 1'b1;
    tick(4);
    chk("rise", o_cause_flags[2], 1'b1);
    chk("no req", o_irq_pending, 1'b0);
  endtask : t_nmi

  // A clear in interrupt mode with the pin low ends in a held reset
  task automatic t_pin_held();
    i_reset_pin_n = 1'b0;
    tick(4);
    pulse(i_wdt_key_viol);
    tick(4);
    chk("mode", o_pin_nmi_mode, SRN_RST_PIN_MODE);
    chk("held", o_resets, 2'b11);
    i_reset_pin_n = 1'b1;
    wait_fetch(SRN_VEC_RESET);
  endtask : t_pin_held

  // Pending requests are taken in chain order
  task automatic t_prio();
    slow = 1'b1;
    i_psw = 16'h0008;
    pulse(i_psw_wr);
    i_irq_req = 13'h1008;
    wait_fetch(16'hfffa);
    i_irq_req = 13'h0;
    pulse(i_psw_wr);
    i_nmi_en = 3'h2;
    pulse(i_nmi_en_wr);
    i_irq_req = 13'h0008;
    pulse(i_osc_fault);
    wait_fetch(SRN_VEC_NMI);
    i_irq_req = 13'h0;
  endtask : t_prio

  // Print counts and verdict, then stop
  task automatic give_verdict();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // Cut a hang short
  always @(posedge i_sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      give_verdict();
    end
  end

  // Main sequence
  initial
  begin
    {i_reset, i_reset_pin_n} = 2'b11;
    {i_supply_monitor_low, i_monitor_reset_option} = 2'b00;
    {i_wdt_expire, i_wdt_key_viol, i_flash_key_viol} = 3'h0;
    {i_osc_fault, i_flash_access_viol, i_flag_clr, slow} = 4'h0;
    {i_pin_nmi_mode_wr, i_pin_nmi_mode, i_pin_edge_select} = 3'h0;
    {i_wdt_interval_wr, i_nmi_en_wr, i_psw_wr} = 3'h0;
    i_wdt_interval = 1'b1;
    i_psw = 16'h0;
    i_irq_req = 13'h0;
    i_nmi_en = 3'h0;
    tick(10);
    chk("por", o_resets, 2'b11);
    chk("gpio", o_gpio_force_input, 1'b1);
    i_reset = 1'b0;
    wait_fetch(SRN_VEC_RESET);
    chk("mode", o_pin_nmi_mode, SRN_RST_PIN_MODE);
    chk("global enable", o_global_irq_enable, 1'b0);
    t_pin_reset();
    t_clears();
    t_nmi();
    t_pin_held();
    t_prio();
    give_verdict();
  end
endmodule : tb
